/* File: inc/pdmc_params.svh */
// Constants for the power-down mode controller: offsets, fields, codes and timing.
// Notes on behaviour
// R1: Mode chosen from control register bits 10-15.
// R2: Software writes the whole select field at once.
// R3: Software writes zero to field bit 15.
// R4: Light sleep starts eight to nine cycles later.
// R5: Unenabled wake resumes at the sleep point.
// R6: Enabled wake runs service routine, then resumes.
// R7: Service routine needs global and nonmaskable enables.
// R8: Deep modes end only on device reset.
// R9: Decode none and the two light sleep codes.
// R10: Decode halt and loop-stop codes; others reserved.
// R11: Light sleep gates CPU clock, DMA continues.
// R12: Clock-halt mode stops the loop output clock.
// R13: Loop-stop mode stops loop input, needs relock.
// R14: Powered-down indicator high in both deep modes.
// R15: Deep modes keep registers and freeze outputs.
// R16: Relock wait typical 75, worst 150% more.
// R17: Full variant eight multipliers, reduced variant four.
// R18: CPU clock is reference times factor, or bypass.
// R19: Wake detector runs while the CPU clock is gated.
`ifndef PDMC_PARAMS_SVH
`define PDMC_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PDMC_ADDR_W 12
`define PDMC_CSR_OFS 12'h000
`define PDMC_IMR_OFS 12'h004
`define PDMC_STAT_OFS 12'h008
`define PDMC_CSR_RST 32'h0000_0000
`define PDMC_IMR_RST 32'h0000_0000

// ----------------------------------------
// Fields
// ----------------------------------------
`define PDMC_IRQ_ALLOW_BIT 0
`define PDMC_NMI_GATE_BIT 1
`define PDMC_MASK_LSB 4
`define PDMC_PDS_LSB 10
`define PDMC_PDS_W 6

// ----------------------------------------
// Select field codes
// ----------------------------------------
`define PDMC_PDS_NONE 6'h00
`define PDMC_PDS_LIGHT_EN 6'h09
`define PDMC_PDS_LIGHT_ANY 6'h11
`define PDMC_PDS_HALT 6'h1A
`define PDMC_PDS_LSTOP 6'h1C

// ----------------------------------------
// Timing
// ----------------------------------------
`define PDMC_CLK_MHZ 100
`define PDMC_ENTRY_CYC 8
`define PDMC_LOCK_TYP_US 75
`define PDMC_LOCK_MAX_PCT 250
`define PDMC_RELOCK_CYC ((`PDMC_LOCK_TYP_US * `PDMC_CLK_MHZ * `PDMC_LOCK_MAX_PCT) / 100)

`endif

/* File: inc/pdmc_pkg.sv */
// Types shared by the power-down mode controller modules.
package pdmc_pkg;

	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_ENTRY = 5'h02,
		ST_LIGHT = 5'h04,
		ST_DEEP = 5'h08,
		ST_RELOCK = 5'h10
	} pdmc_state_e;

	typedef enum logic [2:0] {
		MODE_NONE = 3'h0,
		MODE_LIGHT_EN = 3'h1,
		MODE_LIGHT_ANY = 3'h2,
		MODE_HALT = 3'h3,
		MODE_LSTOP = 3'h4,
		MODE_RSVD = 3'h5
	} pdmc_mode_e;

endpackage : pdmc_pkg

/* File: src/pdmc_mode_decode.sv */
// Select field decoder and clock multiplier strap decoder.
`timescale 1ns/10ps
`default_nettype none
`include "pdmc_params.svh"
module pdmc_mode_decode
	import pdmc_pkg::*;
#(
	parameter bit FULL_PIN = 1'b1
) (
	// Inputs
	input wire logic [5:0] sel_i,
	input wire logic [2:0] strap_i,
	// Decoded results
	output pdmc_mode_e mode_o,
	output logic [3:0] factor_o,
	output logic bypass_o
);

	function automatic logic [3:0] strap_factor(input logic [2:0] s);
		case (s)
			3'h0: strap_factor = 4'h1;
			3'h1: strap_factor = 4'h4;
			3'h2: strap_factor = 4'h8;
			3'h3: strap_factor = 4'hA;
			3'h4: strap_factor = 4'h6;
			3'h5: strap_factor = 4'h9;
			3'h6: strap_factor = 4'h7;
			default: strap_factor = 4'hB;
		endcase
	endfunction : strap_factor

	// The reduced-pin variant has no top strap pin, so it reads as zero.
	wire logic [2:0] eff_strap = FULL_PIN ? strap_i : {1'b0, strap_i[1:0]}; // R17

	assign factor_o = strap_factor(eff_strap); // R18
	assign bypass_o = (eff_strap == 3'h0); // R18

	assign mode_o = (sel_i == `PDMC_PDS_NONE) ? MODE_NONE : // R9
		(sel_i == `PDMC_PDS_LIGHT_EN) ? MODE_LIGHT_EN : // R9
		(sel_i == `PDMC_PDS_LIGHT_ANY) ? MODE_LIGHT_ANY : // R9
		(sel_i == `PDMC_PDS_HALT) ? MODE_HALT : // R10
		(sel_i == `PDMC_PDS_LSTOP) ? MODE_LSTOP : MODE_RSVD; // R10

endmodule : pdmc_mode_decode
`default_nettype wire

/* File: src/pdmc_top.sv */
// Power-down mode controller: register file, sleep sequencing and clock control outputs.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "pdmc_params.svh"
module pdmc_top
	import pdmc_pkg::*;
#(
	parameter int IRQ_W = 4,
	parameter bit FULL_PIN = 1'b1,
	parameter int RELOCK_CYC = `PDMC_RELOCK_CYC
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// APB slave
	input wire logic [`PDMC_ADDR_W-1:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Pins
	input wire logic [IRQ_W-1:0] irq_i,
	input wire logic [2:0] multiplier_select_i,
	// Clock control
	output logic cpu_clk_en_o,
	output logic dma_run_o,
	output logic pll_out_stop_o,
	output logic pll_in_stop_o,
	output logic powered_down_indicator_o,
	output logic io_freeze_o,
	output logic relock_busy_o,
	output logic [3:0] mult_factor_o,
	output logic pll_bypass_o,
	// Core handshake
	output logic isr_take_o,
	output logic resume_o
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	localparam int CNT_W = $clog2(RELOCK_CYC + 1);

	if (IRQ_W < 1 || IRQ_W > 28) begin : g_bad_irq
		$error("IRQ_W must be between 1 and 28.");
	end
	if (RELOCK_CYC < `PDMC_ENTRY_CYC) begin : g_bad_relock
		$error("RELOCK_CYC must not be below the entry delay.");
	end

	// ----------------------------------------
	// Registers and synchronisers
	// ----------------------------------------
	pdmc_state_e state_ff, nxt_state;
	logic [31:0] csr_ff;
	logic [31:0] imr_ff;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [2:0] strap1_ff;
	logic [2:0] strap2_ff;
	logic [2:0] strap_ff;
	logic deep_halt_ff;

	always_ff @(posedge sys_clk_i) begin
		strap1_ff <= multiplier_select_i;
		strap2_ff <= strap1_ff;
	end

	// ----------------------------------------
	// Decoders
	// ----------------------------------------
	pdmc_mode_e wr_mode;
	pdmc_mode_e cur_mode;
	wire logic [3:0] factor;
	wire logic bypass;
	wire logic irq_any;
	wire logic irq_en;

	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			strb_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : strb_merge

	wire logic acc = psel_i && penable_i && pready_o;
	wire logic setup = psel_i && !penable_i;
	wire logic hit_csr = (paddr_i == `PDMC_CSR_OFS);
	wire logic hit_imr = (paddr_i == `PDMC_IMR_OFS);
	wire logic hit_stat = (paddr_i == `PDMC_STAT_OFS);
	wire logic unmapped = !(hit_csr || hit_imr || hit_stat);
	// Contents are held in deep modes; a bus write there is dropped.
	wire logic wr_ok = acc && pwrite_i && !pslverr_o && (state_ff != ST_DEEP); // R15
	wire logic [31:0] csr_new = strb_merge(csr_ff, pwdata_i, pstrb_i);
	wire logic wr_csr = wr_ok && hit_csr;
	wire logic wr_imr = wr_ok && hit_imr;
	wire logic [5:0] new_sel = csr_new[`PDMC_PDS_LSB +: `PDMC_PDS_W]; // R1
	wire logic [5:0] cur_sel = csr_ff[`PDMC_PDS_LSB +: `PDMC_PDS_W];
	wire logic global_irq_allow = csr_ff[`PDMC_IRQ_ALLOW_BIT];
	wire logic nonmaskable_gate_bit = imr_ff[`PDMC_NMI_GATE_BIT];

	// Only a write taken while running starts a sequence; reserved codes do nothing.
	wire logic go = wr_csr && (state_ff == ST_RUN) && (wr_mode != MODE_NONE) &&
		(wr_mode != MODE_RSVD); // R10

	pdmc_mode_decode #(
		.FULL_PIN(FULL_PIN)
	) u_dec (
		.sel_i(new_sel),
		.strap_i(strap_ff),
		.mode_o(wr_mode),
		.factor_o(factor),
		.bypass_o(bypass)
	);

	pdmc_mode_decode #(
		.FULL_PIN(FULL_PIN)
	) u_cur (
		.sel_i(cur_sel),
		.strap_i(3'h0),
		.mode_o(cur_mode),
		.factor_o(),
		.bypass_o()
	);

	pdmc_wake_detect #(
		.IRQ_W(IRQ_W)
	) u_wake (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.irq_i(irq_i),
		.mask_i(imr_ff[`PDMC_MASK_LSB +: IRQ_W]),
		.any_o(irq_any),
		.enabled_o(irq_en)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	wire logic light_now = (cur_mode == MODE_LIGHT_EN) || (cur_mode == MODE_LIGHT_ANY);
	wire logic wake = (state_ff == ST_LIGHT) &&
		(irq_en || ((cur_mode == MODE_LIGHT_ANY) && irq_any)); // R9
	wire logic take_isr = wake && irq_en && global_irq_allow && nonmaskable_gate_bit; // R7
	wire logic cnt_zero = (cnt_ff == '0);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ST_RELOCK: begin // R16
				nxt_cnt = cnt_ff - 1'b1;
				if (bypass || cnt_zero) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (go) begin
					nxt_state = ST_ENTRY;
					nxt_cnt = CNT_W'(`PDMC_ENTRY_CYC - 1); // R4
				end
			end
			ST_ENTRY: begin
				nxt_cnt = cnt_ff - 1'b1;
				if (cnt_zero) begin
					nxt_state = light_now ? ST_LIGHT : ST_DEEP; // R4
				end
			end
			ST_LIGHT: begin
				if (wake) begin
					nxt_state = ST_RUN; // R5 R6
				end
			end
			default: begin
				nxt_state = ST_DEEP; // R8
			end
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			state_ff <= ST_RELOCK; // R13
			cnt_ff <= CNT_W'(RELOCK_CYC - 1);
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// The strap is caught only while relocking, so a pin change in normal running has no effect.
	always_ff @(posedge sys_clk_i) begin
		if (state_ff == ST_RELOCK) begin
			strap_ff <= strap2_ff; // R17
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			deep_halt_ff <= 1'b0;
		end else if (go) begin
			deep_halt_ff <= (wr_mode == MODE_HALT);
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			csr_ff <= `PDMC_CSR_RST;
		end else begin
			// A write that meets a wake still lands; only the select field is cleared.
			if (wr_csr) begin
				csr_ff <= csr_new; // R1
			end
			if (wake) begin
				csr_ff[`PDMC_PDS_LSB +: `PDMC_PDS_W] <= `PDMC_PDS_NONE;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			imr_ff <= `PDMC_IMR_RST;
		end else if (wr_imr) begin
			imr_ff <= strb_merge(imr_ff, pwdata_i, pstrb_i);
		end
	end

	wire logic [31:0] stat_word = {15'h0000, bypass, 4'h0, factor, 3'h0, state_ff};
	wire logic [31:0] rd_word = hit_csr ? csr_ff : hit_imr ? imr_ff : hit_stat ? stat_word : 32'h0000_0000;

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= setup;
			pslverr_o <= setup && unmapped;
			prdata_o <= (setup && !pwrite_i) ? rd_word : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	wire logic nxt_deep = (nxt_state == ST_DEEP);
	wire logic nxt_halt = nxt_deep && (state_ff == ST_ENTRY ? (cur_mode == MODE_HALT) : deep_halt_ff);

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			cpu_clk_en_o <= 1'b0;
			dma_run_o <= 1'b1;
			pll_out_stop_o <= 1'b0;
			pll_in_stop_o <= 1'b0;
			powered_down_indicator_o <= 1'b0;
			io_freeze_o <= 1'b0;
			relock_busy_o <= 1'b1;
			isr_take_o <= 1'b0;
			resume_o <= 1'b0;
			mult_factor_o <= 4'h1;
			pll_bypass_o <= 1'b1;
		end else begin
			cpu_clk_en_o <= (nxt_state == ST_RUN) || (nxt_state == ST_ENTRY); // R11
			dma_run_o <= !nxt_deep; // R11
			pll_out_stop_o <= nxt_halt; // R12
			pll_in_stop_o <= nxt_deep && !nxt_halt; // R13
			powered_down_indicator_o <= nxt_deep; // R14
			io_freeze_o <= nxt_deep; // R15
			relock_busy_o <= (nxt_state == ST_RELOCK); // R13
			isr_take_o <= take_isr; // R6 R7
			resume_o <= wake && !take_isr; // R5
			mult_factor_o <= factor; // R18
			pll_bypass_o <= bypass; // R18
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	sequence s_light_go;
		go && ((wr_mode == MODE_LIGHT_EN) || (wr_mode == MODE_LIGHT_ANY));
	endsequence
	sequence s_entry_wait;
		cpu_clk_en_o [*8] ##1 !cpu_clk_en_o;
	endsequence

	a_entry_latency: assert property (s_light_go |-> ##1 s_entry_wait) // R4
		else $error("Light sleep did not start eight cycles after the write.");
	a_deep_stays: assert property ((state_ff == ST_DEEP) |=> (state_ff == ST_DEEP) && powered_down_indicator_o) // R8
		else $error("Deep sleep was left without reset.");
	a_pd_indicator: assert property ((powered_down_indicator_o == (state_ff == ST_DEEP)) && // R14
		(powered_down_indicator_o == (pll_out_stop_o || pll_in_stop_o)))
		else $error("Indicator disagrees with the deep mode outputs.");
	a_isr_gate: assert property (isr_take_o |-> $past(global_irq_allow && nonmaskable_gate_bit && irq_en)) // R7
		else $error("Service routine taken without both enables.");
	a_wake_resume: assert property ((isr_take_o || resume_o) |-> cpu_clk_en_o && !$past(cpu_clk_en_o)) // R5
		else $error("Wake did not reopen the CPU clock at the sleep point.");
	a_light_dma: assert property ((state_ff == ST_LIGHT) |-> dma_run_o && !cpu_clk_en_o) // R11
		else $error("Light sleep blocked DMA or left the CPU clock running.");
	a_halt_excl: assert property (pll_out_stop_o |-> !pll_in_stop_o && deep_halt_ff) // R12
		else $error("Clock-halt mode drove the wrong loop stop.");
	a_frozen_regs: assert property ((state_ff == ST_DEEP) |=> $stable(csr_ff) && $stable(imr_ff)) // R15
		else $error("Registers changed during deep sleep.");
	a_reserved_ign: assert property ((wr_csr && (state_ff == ST_RUN) && (wr_mode == MODE_RSVD)) // R10
		|=> (state_ff == ST_RUN) [*2])
		else $error("A reserved code started a sleep sequence.");

endmodule : pdmc_top
`default_nettype wire

/* File: src/pdmc_wake_detect.sv */
// Interrupt pin synchroniser and wake qualification on the free-running clock.
`timescale 1ns/10ps
`default_nettype none
module pdmc_wake_detect #(
	parameter int IRQ_W = 4
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Interrupt pins and enables
	input wire logic [IRQ_W-1:0] irq_i,
	input wire logic [IRQ_W-1:0] mask_i,
	// Qualified results
	output logic any_o,
	output logic enabled_o
);

	logic [IRQ_W-1:0] sync1_ff;
	logic [IRQ_W-1:0] sync2_ff;

	// Runs on the ungated clock so a pending line can reopen the CPU clock.
	always_ff @(posedge sys_clk_i) begin // R19
		if (!nrst_i) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= irq_i;
			sync2_ff <= sync1_ff;
		end
	end

	assign any_o = |sync2_ff; // R19
	assign enabled_o = |(sync2_ff & mask_i); // R19

endmodule : pdmc_wake_detect
`default_nettype wire

/* File: tb/pdmc_irq_src.sv */
// Interrupt source model that feeds the controller's interrupt pins.
`timescale 1ns/10ps
`default_nettype none
module pdmc_irq_src #(
	parameter int IRQ_W = 4
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// Requests and acknowledge
	input wire logic [IRQ_W-1:0] raise_i,
	input wire logic ack_i,
	// Interrupt lines
	output logic [IRQ_W-1:0] irq_o
);
	// Lines stay high until the core takes the wake, since the pins are sampled only after two flops.
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i || ack_i) begin
			irq_o <= '0;
		end else begin
			irq_o <= irq_o | raise_i;
		end
	end
endmodule : pdmc_irq_src
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking testbench for the power-down mode controller.
`timescale 1ns/10ps
`default_nettype none
`include "pdmc_params.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fails++; $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] raise = 4'h0;
	logic [2:0] strap = 3'h1;
	logic [3:0] irq;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, clk_en, dma_run, out_stop, in_stop, pdi, freeze, relock, bypass, isr, resume;
	logic [3:0] factor;
	logic [3:0] ftab [8] = '{4'h1, 4'h4, 4'h8, 4'hA, 4'h6, 4'h9, 4'h7, 4'hB};
	int fails = 0;
	int checks_done = 0;

	always #5 sys_clk_i = ~sys_clk_i;

	pdmc_top #(.IRQ_W(4), .FULL_PIN(1'b1), .RELOCK_CYC(20)) uut (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .irq_i(irq), .multiplier_select_i(strap), .cpu_clk_en_o(clk_en),
		.dma_run_o(dma_run), .pll_out_stop_o(out_stop), .pll_in_stop_o(in_stop),
		.powered_down_indicator_o(pdi), .io_freeze_o(freeze), .relock_busy_o(relock),
		.mult_factor_o(factor), .pll_bypass_o(bypass), .isr_take_o(isr), .resume_o(resume));

	pdmc_irq_src #(.IRQ_W(4)) src (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .raise_i(raise),
		.ack_i(isr | resume), .irq_o(irq));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task complete_run();
		if (fails == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run

	// Entered just after a rising edge; returns one edge after the access completes.
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		n = 0;
		@(posedge sys_clk_i);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge sys_clk_i);
			n++;
		end
		`CHK("apb answer", 1'b1, pready)
		if (pready !== 1'b1) complete_run();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk_i);
	endtask : apb

	task reset_dut(input logic [2:0] s);
		int n;
		nrst_i <= 1'b0;
		strap <= s;
		repeat (12) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		n = 0;
		`CHK("relock busy", 1'b1, relock)
		while (clk_en !== 1'b1 && n < 60) begin
			@(posedge sys_clk_i);
			n++;
		end
		`CHK("relock end", 1'b1, clk_en)
		if (clk_en !== 1'b1) complete_run();
		`CHK("relock flag", 1'b0, relock)
		`CHK("relock length", s != 3'h0, n > 15)
		@(posedge sys_clk_i);
	endtask : reset_dut

	task light(input logic [5:0] code, input logic allow, input logic [31:0] imr, input logic [3:0] wake,
		input logic isr_exp);
		int n;
		apb(1'b1, `PDMC_IMR_OFS, imr);
		apb(1'b1, `PDMC_CSR_OFS, {16'h0, code, 9'h0, allow});
		n = 1;
		@(negedge sys_clk_i);
		while (clk_en === 1'b1 && n < 30) begin
			n++;
			@(negedge sys_clk_i);
		end
		`CHK("entry delay", 8, n)
		if (clk_en === 1'b1) complete_run();
		`CHK("dma in light", 1'b1, dma_run)
		`CHK("indicator light", 1'b0, pdi)
		@(posedge sys_clk_i);
		if (code == `PDMC_PDS_LIGHT_EN) begin
			raise <= 4'h8;
			@(posedge sys_clk_i);
			raise <= 4'h0;
			repeat (10) @(posedge sys_clk_i);
			`CHK("still asleep", 1'b0, clk_en)
		end
		raise <= wake;
		@(posedge sys_clk_i);
		raise <= 4'h0;
		n = 0;
		while (!(isr === 1'b1 || resume === 1'b1) && n < 20) begin
			@(negedge sys_clk_i);
			n++;
		end
		`CHK("service", isr_exp, isr)
		`CHK("resume", !isr_exp, resume)
		`CHK("clock back", 1'b1, clk_en)
		if (isr !== 1'b1 && resume !== 1'b1) complete_run();
		@(posedge sys_clk_i);
		apb(1'b0, `PDMC_CSR_OFS, 32'h0);
		`CHK("field cleared", 6'h00, rd[15:10])
	endtask : light

	task deep(input logic [5:0] code, input logic out_exp, input logic in_exp);
		apb(1'b1, `PDMC_CSR_OFS, {16'h0, code, 10'h0});
		repeat (10) @(posedge sys_clk_i);
		raise <= 4'hF;
		@(posedge sys_clk_i);
		raise <= 4'h0;
		repeat (10) @(posedge sys_clk_i);
		`CHK("deep clock", 1'b0, clk_en)
		`CHK("loop out stop", out_exp, out_stop)
		`CHK("loop in stop", in_exp, in_stop)
		`CHK("indicator", 1'b1, pdi)
		`CHK("freeze", 1'b1, freeze)
		`CHK("dma halted", 1'b0, dma_run)
		apb(1'b0, `PDMC_STAT_OFS, 32'h0);
		`CHK("deep state", 5'h08, rd[4:0])
		reset_dut(3'h1);
		`CHK("indicator off", 1'b0, pdi)
	endtask : deep

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 8; i++) begin
			reset_dut(i[2:0]);
			`CHK("factor", ftab[i], factor)
			`CHK("bypass", i == 0, bypass)
		end
		reset_dut(3'h1);
		apb(1'b1, `PDMC_CSR_OFS, 32'h0000_0001);
		apb(1'b0, `PDMC_CSR_OFS, 32'h0);
		`CHK("control", 32'h0000_0001, rd)
		apb(1'b0, `PDMC_STAT_OFS, 32'h0);
		`CHK("status", 17'h00401, rd[16:0])
		apb(1'b0, 12'h00C, 32'h0);
		`CHK("unmapped", 1'b1, err)
		apb(1'b1, `PDMC_CSR_OFS, {16'h0, 6'h05, 10'h0});
		repeat (12) @(posedge sys_clk_i);
		`CHK("reserved code", 1'b1, clk_en)
		light(`PDMC_PDS_LIGHT_EN, 1'b1, 32'h12, 4'h1, 1'b1);
		light(`PDMC_PDS_LIGHT_EN, 1'b1, 32'h10, 4'h1, 1'b0);
		light(`PDMC_PDS_LIGHT_EN, 1'b0, 32'h12, 4'h1, 1'b0);
		light(`PDMC_PDS_LIGHT_ANY, 1'b1, 32'h12, 4'h4, 1'b0);
		deep(`PDMC_PDS_HALT, 1'b1, 1'b0);
		deep(`PDMC_PDS_LSTOP, 1'b0, 1'b1);
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fails++;
		complete_run();
	end
endmodule : testbench
`default_nettype wire
